// file: host_reg_model.sv
`timescale 1ns/1ps
module host_reg_model (
  // Clock
  input wire logic core_clk_in,
  // Register requests
  output mode_cfg_pkg::reg_req_t req_out
);
  initial req_out = '0;
  // Holds until the next call, so accesses may run back to back
  task automatic access(input logic w, input logic r,
    input logic [7:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (w && a == 8'h25)
      v = d & 16'h2300;
    @(posedge core_clk_in);
    #1;
    req_out = '{wr: w, rd: r, addr: a, wdata: v};
  endtask
endmodule

// file: mode_cfg_pkg.sv
package mode_cfg_pkg;

  // Register offsets on the register port
  localparam logic [7:0] ADDR_DEVICE_MODE = 8'h25;
  localparam logic [7:0] ADDR_INTERFACE = 8'h26;
  localparam logic [7:0] ADDR_SRAM_POINTER = 8'h2b;
  localparam logic [7:0] ADDR_SRAM_DATA = 8'h2c;
  localparam logic [7:0] ADDR_BROADCAST = 8'h50;

  // Widths
  localparam int REG_W = 16;
  localparam int ADDR_W = 8;
  localparam int PTR_W = 8;
  localparam int CODE_W = 12;

  // Reset values
  localparam logic [15:0] RESET_DEVICE_MODE = 16'h0000;
  localparam logic [15:0] RESET_INTERFACE = 16'h0000;
  localparam logic [7:0] RESET_SRAM_POINTER = 8'h00;
  localparam logic [15:0] RESET_BROADCAST = 16'h0000;
  localparam logic [15:0] RESET_READ_DATA = 16'h0000;

  // Field positions
  localparam int LOW_POWER_BIT = 13;
  localparam int PROTECT_LSB = 8;
  localparam int TIMEOUT_EN_BIT = 12;
  localparam int PMBUS_EN_BIT = 8;
  localparam int FAST_READBACK_BIT = 2;
  localparam int READBACK_EN_BIT = 0;

  // Writable bits of the interface register; the rest read as zero
  localparam logic [15:0] INTERFACE_MASK = 16'h1105;

  // Output code stepping while slewing, codes per clock
  localparam logic [11:0] SLEW_STEP = 12'h001;

  typedef enum logic [1:0] {
    ACT_HIZ = 2'h0,
    ACT_NVM = 2'h1,
    ACT_MARGIN_LOW = 2'h2,
    ACT_MARGIN_HIGH = 2'h3
  } protect_action_t;

  // Gray along idle, load, slew, power-down
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOAD = 2'h1,
    ST_SLEW = 2'h3,
    ST_HIZ = 2'h2
  } protect_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic low_power;
    logic i2c_timeout_en;
    logic pmbus_en;
    logic fast_readback_en;
    logic readback_en;
  } iface_ctrl_t;

endpackage

// file: mode_interface_sram_regs.sv
`timescale 1ns/1ps
// Function
// - Low-power select bit enters low-power condition
// - Action 00: protect goes straight to Hi-Z
// - Action 01: load NVM code, then Hi-Z
// - Action 10: slew to margin-low, then Hi-Z
// - Action 11: slew to margin-high, then Hi-Z
// - I2C timeout only while enable bit set
// - PMBus accepted only while enable bit set
// - Fast readback mode follows its enable bit
// - Readback output on GPIO follows enable bit
// - Eight-bit pointer selects next SRAM location
// - Pointer advances by one after data write
// - Data register writes or reads pointed location

module mode_interface_sram_regs #(
  parameter int CODE_W = mode_cfg_pkg::CODE_W
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Register port from the serial interface logic
  input wire mode_cfg_pkg::reg_req_t reg_req_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Protect sequencing
  input wire logic protect_event_in,
  input wire logic protect_release_in,
  input wire logic [CODE_W-1:0] active_code_in,
  input wire logic [CODE_W-1:0] nvm_code_in,
  input wire logic [CODE_W-1:0] margin_low_code_in,
  input wire logic [CODE_W-1:0] margin_high_code_in,
  output logic [CODE_W-1:0] output_code_out,
  output logic hiz_power_down_out,
  output logic protect_busy_out,
  // Interface and mode controls
  output mode_cfg_pkg::iface_ctrl_t iface_ctrl_out,
  output logic [15:0] broadcast_code_out
);

  typedef struct packed {
    logic [15:0] device_mode;
    logic [15:0] iface;
    logic [7:0] sram_pointer;
    logic [15:0] broadcast;
    logic rd_pending;
    logic rd_from_sram;
    logic [15:0] rd_hold;
    logic [15:0] rdata;
    logic rvalid;
    mode_cfg_pkg::protect_state_t pstate;
    logic [CODE_W-1:0] code;
    logic [CODE_W-1:0] target;
    logic hiz;
  } regs_state_t;

  regs_state_t state;
  regs_state_t next_state;

  logic sram_wr;
  logic [15:0] sram_rdata;
  mode_cfg_pkg::protect_action_t action;

  assign action = mode_cfg_pkg::protect_action_t'(
    state.device_mode[mode_cfg_pkg::PROTECT_LSB +: 2]);
  assign sram_wr = reg_req_in.wr &&
    (reg_req_in.addr == mode_cfg_pkg::ADDR_SRAM_DATA);

  sram_window_mem #(
    .AW(mode_cfg_pkg::PTR_W),
    .DW(mode_cfg_pkg::REG_W)
  ) i_sram_window_mem (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .wr_en_in(sram_wr),
    .addr_in(state.sram_pointer),
    .wdata_in(reg_req_in.wdata),
    .rdata_out(sram_rdata)
  );

  always_comb
  begin
    next_state = state;
    next_state.rvalid = 1'b0;

    // Register writes; reserved mode bits are stored as written
    if (reg_req_in.wr)
    begin
      if (reg_req_in.addr == mode_cfg_pkg::ADDR_DEVICE_MODE)
      begin
        next_state.device_mode = reg_req_in.wdata;
      end
      else if (reg_req_in.addr == mode_cfg_pkg::ADDR_INTERFACE)
      begin
        next_state.iface = reg_req_in.wdata & mode_cfg_pkg::INTERFACE_MASK;
      end
      else if (reg_req_in.addr == mode_cfg_pkg::ADDR_SRAM_POINTER)
      begin
        next_state.sram_pointer = reg_req_in.wdata[7:0];
      end
      else if (reg_req_in.addr == mode_cfg_pkg::ADDR_SRAM_DATA)
      begin
        // Wraps from the last location back to zero
        next_state.sram_pointer = state.sram_pointer + 8'h01;
      end
      else if (reg_req_in.addr == mode_cfg_pkg::ADDR_BROADCAST)
      begin
        next_state.broadcast = reg_req_in.wdata;
      end
    end

    // Reads take two cycles so SRAM data can come from its own register
    next_state.rd_pending = reg_req_in.rd && !reg_req_in.wr;
    next_state.rd_from_sram = 1'b0;
    next_state.rd_hold = mode_cfg_pkg::RESET_READ_DATA;
    if (reg_req_in.rd && !reg_req_in.wr)
    begin
      if (reg_req_in.addr == mode_cfg_pkg::ADDR_DEVICE_MODE)
      begin
        next_state.rd_hold = state.device_mode;
      end
      else if (reg_req_in.addr == mode_cfg_pkg::ADDR_INTERFACE)
      begin
        next_state.rd_hold = state.iface;
      end
      else if (reg_req_in.addr == mode_cfg_pkg::ADDR_SRAM_POINTER)
      begin
        next_state.rd_hold = {8'h00, state.sram_pointer};
      end
      else if (reg_req_in.addr == mode_cfg_pkg::ADDR_SRAM_DATA)
      begin
        next_state.rd_from_sram = 1'b1;
      end
      else if (reg_req_in.addr == mode_cfg_pkg::ADDR_BROADCAST)
      begin
        next_state.rd_hold = state.broadcast;
      end
    end
    if (state.rd_pending)
    begin
      next_state.rvalid = 1'b1;
      next_state.rdata = state.rd_from_sram ? sram_rdata : state.rd_hold;
    end

    // Protect sequencer
    case (state.pstate)
      mode_cfg_pkg::ST_IDLE:
      begin
        next_state.code = active_code_in;
        next_state.hiz = 1'b0;
        if (protect_event_in)
        begin
          case (action)
            mode_cfg_pkg::ACT_HIZ:
            begin
              next_state.hiz = 1'b1;
              next_state.pstate = mode_cfg_pkg::ST_HIZ;
            end
            mode_cfg_pkg::ACT_NVM:
            begin
              next_state.code = nvm_code_in;
              next_state.pstate = mode_cfg_pkg::ST_LOAD;
            end
            mode_cfg_pkg::ACT_MARGIN_LOW:
            begin
              next_state.target = margin_low_code_in;
              next_state.pstate = mode_cfg_pkg::ST_SLEW;
            end
            default:
            begin
              next_state.target = margin_high_code_in;
              next_state.pstate = mode_cfg_pkg::ST_SLEW;
            end
          endcase
        end
      end
      mode_cfg_pkg::ST_LOAD:
      begin
        // One cycle at the stored code before powering down
        next_state.hiz = 1'b1;
        next_state.pstate = mode_cfg_pkg::ST_HIZ;
      end
      mode_cfg_pkg::ST_SLEW:
      begin
        if (state.code == state.target)
        begin
          next_state.hiz = 1'b1;
          next_state.pstate = mode_cfg_pkg::ST_HIZ;
        end
        else if (state.code < state.target)
        begin
          if (state.target - state.code <= mode_cfg_pkg::SLEW_STEP)
          begin
            next_state.code = state.target;
          end
          else
          begin
            next_state.code = state.code + mode_cfg_pkg::SLEW_STEP;
          end
        end
        else if (state.code - state.target <= mode_cfg_pkg::SLEW_STEP)
        begin
          next_state.code = state.target;
        end
        else
        begin
          next_state.code = state.code - mode_cfg_pkg::SLEW_STEP;
        end
      end
      default:
      begin
        // Held powered down until the protect condition is released
        next_state.hiz = 1'b1;
        if (protect_release_in)
        begin
          next_state.hiz = 1'b0;
          next_state.pstate = mode_cfg_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      state.device_mode <= mode_cfg_pkg::RESET_DEVICE_MODE;
      state.iface <= mode_cfg_pkg::RESET_INTERFACE;
      state.sram_pointer <= mode_cfg_pkg::RESET_SRAM_POINTER;
      state.broadcast <= mode_cfg_pkg::RESET_BROADCAST;
      state.rd_pending <= 1'b0;
      state.rd_from_sram <= 1'b0;
      state.rd_hold <= mode_cfg_pkg::RESET_READ_DATA;
      state.rdata <= mode_cfg_pkg::RESET_READ_DATA;
      state.rvalid <= 1'b0;
      state.pstate <= mode_cfg_pkg::ST_IDLE;
      state.code <= '0;
      state.target <= '0;
      state.hiz <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign reg_rdata_out = state.rdata;
  assign reg_rvalid_out = state.rvalid;
  assign output_code_out = state.code;
  assign hiz_power_down_out = state.hiz;
  assign protect_busy_out = (state.pstate != mode_cfg_pkg::ST_IDLE);
  assign broadcast_code_out = state.broadcast;

  assign iface_ctrl_out.low_power =
    state.device_mode[mode_cfg_pkg::LOW_POWER_BIT];
  assign iface_ctrl_out.i2c_timeout_en =
    state.iface[mode_cfg_pkg::TIMEOUT_EN_BIT];
  assign iface_ctrl_out.pmbus_en =
    state.iface[mode_cfg_pkg::PMBUS_EN_BIT];
  assign iface_ctrl_out.fast_readback_en =
    state.iface[mode_cfg_pkg::FAST_READBACK_BIT];
  assign iface_ctrl_out.readback_en =
    state.iface[mode_cfg_pkg::READBACK_EN_BIT];

endmodule

// file: mode_interface_sram_regs_properties.sv
`timescale 1ns/1ps
module mode_regs_checker #(
  parameter int CODE_W = mode_cfg_pkg::CODE_W
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Watched ports
  input wire mode_cfg_pkg::reg_req_t reg_req_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic protect_event_in,
  input wire logic protect_release_in,
  input wire logic [CODE_W-1:0] output_code_out,
  input wire logic hiz_power_down_out,
  input wire logic protect_busy_out,
  input wire mode_cfg_pkg::iface_ctrl_t iface_ctrl_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  logic rd_taken;
  logic iface_wr;
  logic mode_wr;
  assign rd_taken = reg_req_in.rd && !reg_req_in.wr;
  assign iface_wr = reg_req_in.wr &&
    reg_req_in.addr == mode_cfg_pkg::ADDR_INTERFACE;
  assign mode_wr = reg_req_in.wr &&
    reg_req_in.addr == mode_cfg_pkg::ADDR_DEVICE_MODE;
  AST_READ_LAT: assert property (
    rd_taken |-> ##2 reg_rvalid_out)
    else $error("read answer missing");
  AST_NO_SPUR: assert property (
    reg_rvalid_out |-> $past(rd_taken, 2))
    else $error("answer without read");
  AST_RDATA_HOLD: assert property (
    !reg_rvalid_out |-> $stable(reg_rdata_out))
    else $error("read data moved");
  AST_RB_BITS: assert property (
    iface_wr |=> iface_ctrl_out.readback_en == $past(reg_req_in.wdata[0])
    && iface_ctrl_out.fast_readback_en == $past(reg_req_in.wdata[2]))
    else $error("readback controls wrong");
  AST_BUS_BITS: assert property (
    iface_wr |=> iface_ctrl_out.pmbus_en == $past(reg_req_in.wdata[8])
    && iface_ctrl_out.i2c_timeout_en == $past(reg_req_in.wdata[12]))
    else $error("bus controls wrong");
  AST_LOW_POWER: assert property (
    mode_wr |=> iface_ctrl_out.low_power == $past(reg_req_in.wdata[13]))
    else $error("low-power select wrong");
  AST_CTRL_HOLD: assert property (
    !reg_req_in.wr |=> $stable(iface_ctrl_out))
    else $error("controls moved without write");
  AST_PROT_START: assert property (
    protect_event_in && !protect_busy_out |=> protect_busy_out)
    else $error("event not taken");
  AST_HIZ_BUSY: assert property (
    hiz_power_down_out |-> protect_busy_out)
    else $error("power-down outside sequence");
  AST_HIZ_HOLD: assert property (
    hiz_power_down_out && !protect_release_in |=> hiz_power_down_out)
    else $error("power-down left early");
  AST_RELEASE: assert property (
    hiz_power_down_out && protect_release_in
    |=> !hiz_power_down_out && !protect_busy_out)
    else $error("release lost");
  AST_SLEW: assert property (
    protect_busy_out && !hiz_power_down_out && $past(protect_busy_out)
    |-> $stable(output_code_out)
    || output_code_out == $past(output_code_out) + 1'b1
    || output_code_out + 1'b1 == $past(output_code_out))
    else $error("slew step too large");
endmodule
bind mode_interface_sram_regs mode_regs_checker #(.CODE_W(CODE_W))
  i_mode_regs_checker (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .protect_event_in(protect_event_in),
  .protect_release_in(protect_release_in),
  .output_code_out(output_code_out),
  .hiz_power_down_out(hiz_power_down_out),
  .protect_busy_out(protect_busy_out), .iface_ctrl_out(iface_ctrl_out));

// file: sram_window_mem.sv
`timescale 1ns/1ps

module sram_window_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Access port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  output logic [DW-1:0] rdata_out
);

  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] cells;
    logic [DW-1:0] rdata;
  } mem_state_t;

  mem_state_t state;
  mem_state_t next_state;

  always_comb
  begin
    next_state = state;
    if (wr_en_in)
    begin
      next_state.cells[addr_in] = wdata_in;
    end
    // Old contents on a same-cycle write; reads never see a write in flight
    next_state.rdata = state.cells[addr_in];
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rdata_out = state.rdata;

endmodule

// file: test_mode_interface_sram_regs.sv
`timescale 1ns/1ps
module test_mode_interface_sram_regs;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  mode_cfg_pkg::reg_req_t req;
  logic [15:0] rdata;
  logic rvalid;
  logic ev = 1'b0;
  logic rel = 1'b0;
  logic [11:0] act = 12'h000, nvm = 12'h000, mlo = 12'h000, mhi = 12'h000;
  logic [11:0] code;
  logic hiz;
  logic busy;
  logic [15:0] bcast;
  mode_cfg_pkg::iface_ctrl_t ctrl;
  logic [15:0] expq [$];
  logic [15:0] d [3];
  logic [15:0] v;
  logic [7:0] ra [5] = '{8'h25, 8'h26, 8'h2b, 8'h2c, 8'h50};
  int mismatches = 0;
  int checks_done = 0;
  int n;
  always #2.5 core_clk_in = ~core_clk_in;
  host_reg_model i_host_reg_model (.core_clk_in(core_clk_in), .req_out(req));
  mode_interface_sram_regs i_mode_interface_sram_regs (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .protect_event_in(ev), .protect_release_in(rel),
    .active_code_in(act), .nvm_code_in(nvm), .margin_low_code_in(mlo),
    .margin_high_code_in(mhi), .output_code_out(code),
    .hiz_power_down_out(hiz), .protect_busy_out(busy),
    .iface_ctrl_out(ctrl), .broadcast_code_out(bcast));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] x);
    i_host_reg_model.access(1'b1, 1'b0, a, x);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    expq.push_back(e);
    i_host_reg_model.access(1'b0, 1'b1, a, 16'h0000);
  endtask
  task automatic idle(input int c);
    i_host_reg_model.access(1'b0, 1'b0, 8'h00, 16'h0000);
    repeat (c) @(posedge core_clk_in);
    #1;
  endtask
  // Unexpected answers compare against unknown and so always fail
  always @(posedge core_clk_in)
    if (rvalid === 1'b1)
      chk(rdata, expq.size() != 0 ? expq.pop_front() : 16'hxxxx);
  task automatic protect(input logic [1:0] sel);
    int k;
    logic [11:0] tgt;
    k = $urandom_range(15, 0);
    act = 12'h100 + 12'($urandom_range(3000, 0));
    nvm = 12'($urandom);
    mlo = act - 12'(k);
    mhi = act + 12'(k);
    tgt = sel == 2'h1 ? nvm : (sel == 2'h2 ? mlo : mhi);
    wr(8'h25, {6'h00, sel, 8'h00});
    idle(2);
    // Event held through the sequence; a busy sequencer must ignore it
    ev = 1'b1;
    n = 0;
    while (hiz !== 1'b1 && n < 300)
    begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    chk(16'(n), sel == 2'h0 ? 16'h0001 :
      (sel == 2'h1 ? 16'h0002 : 16'(k + 2)));
    if (n == 300)
      report_and_stop();
    if (sel != 2'h0)
      chk({4'h0, code}, {4'h0, tgt});
    ev = 1'b0;
    rel = 1'b1;
    @(posedge core_clk_in);
    #1;
    rel = 1'b0;
    chk({15'h0000, hiz}, 16'h0000);
  endtask
  initial
  begin
    void'($urandom(32'hbcb1fc5e));
    repeat (16) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
    foreach (ra[i])
      rd(ra[i], 16'h0000);
    rd(8'h30, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      v = i == 0 ? 16'hffff : 16'($urandom);
      wr(8'h26, v);
      idle(1);
      chk({11'h000, ctrl},
        {12'h000, v[12], v[8], v[2], v[0]});
      rd(8'h26, v & 16'h1105);
    end
    wr(8'h25, 16'hffff);
    idle(1);
    chk({15'h0000, ctrl.low_power}, 16'h0001);
    rd(8'h25, 16'h2300);
    wr(8'h2b, 16'h00fe);
    for (int i = 0; i < 3; i++)
    begin
      d[i] = 16'($urandom);
      wr(8'h2c, d[i]);
    end
    rd(8'h2b, 16'h0001);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h2b, {8'h00, 8'(8'hfe + i)});
      rd(8'h2c, d[i]);
      rd(8'h2c, d[i]);
    end
    for (int a = 0; a < 8; a++)
      protect(2'(a));
    // Non-zero state before reset, so the reset checks can trip
    wr(8'h2b, 16'h005a);
    v = 16'($urandom);
    wr(8'h50, v);
    wr(8'h30, 16'hffff);
    idle(1);
    chk(bcast, v);
    rd(8'h50, v);
    idle(4);
    rst_in = 1'b1;
    repeat (2) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
    rd(8'h2b, 16'h0000);
    rd(8'h25, 16'h0000);
    idle(4);
    chk({11'h000, ctrl}, 16'h0000);
    chk(bcast, 16'h0000);
    if (expq.size() != 0)
      mismatches++;
    report_and_stop();
  end
endmodule
